/* core/htc_pkg.sv */
package htc_pkg;
// Summary of operation
// RULE1: at start-up use the non-volatile store if valid, else the factory defaults
// RULE2: copy the chosen source into the shadow store and run from the shadow store
// RULE3: shadow store clears on any reset and reloads when the reset ends
// RULE4: factory default store is a constant table the host cannot alter
// RULE5: host sees sixteen registers for status and control over the serial bus (the code reads ten, 0x00 to 0x09; the soft reset register reads as zero)
// RULE6: in host shadow mode the host overwrites shadow words until the next reset
// RULE7: burning is two steps: host fills shadow store, then commands copy to non-volatile
// RULE8: serial port is an I2C slave for standard and fast bit rates
// RULE9: slave address is the default unless the non-volatile store programs another
// RULE10: reset comes from power-up, the reset pin or the software command
// RULE11: interrupt line held low during start-up, released once initialisation ends
// RULE12: host starts no bus transfer before the interrupt line has risen
// RULE13: device stays in reset while the reset pin is low, starts when high
// RULE14: software reset is the key write followed by a zero write to its register
// RULE15: in active and doze modes the interrupt line updates once per scan period
// RULE16: button touch, or release when enabled, raises the interrupt
// RULE17: slider events raise the interrupt, detail in slider and status registers
// RULE18: enabled input pin edges raise the interrupt, detail in input status register
// RULE19: entering active or doze mode raises the interrupt, mode shown in mode register
// RULE20: compensation done, shadow write and burn done raise the interrupt
// RULE21: interrupt line held asserted during every reset
// RULE22: reading the interrupt source register or finishing reset releases the line
// RULE23: an enabled input pin edge also wakes the device from sleep or doze
// RULE24: events arriving while the line is low stay recorded until the source read

localparam int REF_CLK_MHZ = 10;
localparam int PWRUP_US    = 20;
localparam int NVM_WR_US   = 2;
localparam logic [15:0] PWRUP_CYC = 16'(PWRUP_US * REF_CLK_MHZ);
localparam logic [15:0] NVM_WR_CYC = 16'(NVM_WR_US * REF_CLK_MHZ);

localparam logic [6:0] DEF_SLV_ADDR = 7'h2b;
localparam logic [7:0] SRST_KEY     = 8'hde;
localparam logic [7:0] SRST_GO      = 8'h00;

localparam logic [7:0] REG_IRQ     = 8'h00;
localparam logic [7:0] REG_CAPH    = 8'h01;
localparam logic [7:0] REG_CAPL    = 8'h02;
localparam logic [7:0] REG_SLDH    = 8'h03;
localparam logic [7:0] REG_SLDL    = 8'h04;
localparam logic [7:0] REG_GPI     = 8'h05;
localparam logic [7:0] REG_MODE    = 8'h06;
localparam logic [7:0] REG_SHD_CTL = 8'h07;
localparam logic [7:0] REG_SHD_ADR = 8'h08;
localparam logic [7:0] REG_SHD_DAT = 8'h09;
localparam logic [7:0] REG_SRST    = 8'hb1;

localparam int IRQ_MODE = 0;
localparam int IRQ_COMP = 1;
localparam int IRQ_BTN  = 2;
localparam int IRQ_SLD  = 3;
localparam int IRQ_GPI  = 4;
localparam int IRQ_SPMW = 5;
localparam int IRQ_NVMB = 6;

localparam logic [3:0] SHD_ADDR = 4'h0;
localparam logic [3:0] SHD_REL  = 4'h1;
localparam logic [3:0] SHD_RISE = 4'h2;
localparam logic [3:0] SHD_FALL = 4'h3;
localparam logic [3:0] SHD_LAST = 4'hf;

typedef enum logic [1:0] {M_ACTIVE = 2'h0, M_DOZE = 2'h1, M_SLEEP = 2'h2} htc_mode_e;
typedef enum logic [2:0] {
   ST_RST = 3'h0, ST_WAIT = 3'h1, ST_LOAD = 3'h3, ST_RUN = 3'h2, ST_BURN = 3'h6
} htc_st_e;

// read-only factory table
function automatic logic [7:0] factory_default(input logic [3:0] idx);
   case (idx)
      SHD_ADDR: factory_default = {1'b0, DEF_SLV_ADDR};
      SHD_REL:  factory_default = 8'h01;
      default:  factory_default = 8'h00;
   endcase
endfunction
endpackage

/* core/htc_link_if.sv */
`timescale 1ns/1ps
interface htc_link_if;
   logic       wr_tgl;
   logic [7:0] wr_addr;
   logic [7:0] wr_data;
   logic       rd_tgl;
   logic [7:0] rd_addr;
   logic       rd_ack_tgl;
   logic [7:0] rd_data;
   logic [6:0] dev_addr;
   modport link (output wr_tgl, wr_addr, wr_data, rd_tgl, rd_addr,
                 input rd_ack_tgl, rd_data, dev_addr);
   modport core (input wr_tgl, wr_addr, wr_data, rd_tgl, rd_addr,
                 output rd_ack_tgl, rd_data, dev_addr);
endinterface

/* core/htc_sync2.sv */
`timescale 1ns/1ps
module htc_sync2 #(parameter int W = 1) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_q <= '0;
         q      <= '0;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule

/* core/htc_i2c_link.sv */
`timescale 1ns/1ps
module htc_i2c_link (
   input  wire logic i2c_scl,
   input  wire logic reset,
   input  wire logic i2c_sda_in,
   output logic      i2c_sda_oe,
   htc_link_if.link  lk
);
   typedef enum logic [3:0] {
      L_IDLE = 4'h0, L_ADDR = 4'h1, L_AACK = 4'h3, L_PTR = 4'h2, L_PACK = 4'h6,
      L_WDAT = 4'h7, L_WACK = 4'h5, L_RDAT = 4'h4, L_RACK = 4'hc
   } htc_lst_e;
   htc_lst_e   st_q, st_d;
   logic [2:0] cnt_q, cnt_d;
   logic [7:0] sh_q, sh_d, ptr_q, ptr_d, wa_q, wa_d, wd_q, wd_d, ra_q, ra_d;
   logic       rw_q, rw_d, oe_q, oe_d, wt_q, wt_d, rt_q, rt_d;
   logic       sda_pos_q, ack_s;
   logic [7:0] byte_w, rbyte;

   htc_sync2 #(.W(1)) u_ack (.clk(i2c_scl), .rst(reset), .d(lk.rd_ack_tgl), .q(ack_s));

   always_ff @(posedge i2c_scl or posedge reset) begin
      if (reset) sda_pos_q <= 1'b1;
      else sda_pos_q <= i2c_sda_in;
   end

   always_comb begin
      byte_w = {sh_q[6:0], sda_pos_q};
      // prefetched word not yet returned reads as all ones
      rbyte = (ack_s == rt_q) ? lk.rd_data : 8'hff;
      {st_d, cnt_d, sh_d, ptr_d, wa_d, wd_d, ra_d} = {st_q, cnt_q, sh_q, ptr_q, wa_q, wd_q, ra_q};
      {rw_d, oe_d, wt_d, rt_d} = {rw_q, oe_q, wt_q, rt_q};
      if (sda_pos_q && !i2c_sda_in) begin
         // start or repeated start seen while the clock was high
         st_d  = L_ADDR;
         cnt_d = 3'h0;
         oe_d  = 1'b0;
      end else begin
         case (st_q)
            L_ADDR, L_PTR, L_WDAT: begin
               sh_d  = byte_w;
               cnt_d = cnt_q + 3'h1;
               if (cnt_q == 3'h7) begin
                  oe_d = 1'b1;
                  if (st_q == L_ADDR) begin
                     rw_d = byte_w[0];
                     st_d = L_AACK;
                     if (byte_w[7:1] != lk.dev_addr) begin // [RULE9]
                        oe_d = 1'b0;
                        st_d = L_IDLE;
                     end
                  end else if (st_q == L_PTR) begin
                     ptr_d = byte_w;
                     ra_d  = byte_w;
                     rt_d  = ~rt_q;
                     st_d  = L_PACK;
                  end else begin
                     wa_d  = ptr_q;
                     wd_d  = byte_w;
                     wt_d  = ~wt_q;
                     ptr_d = ptr_q + 8'h1;
                     ra_d  = ptr_q + 8'h1;
                     rt_d  = ~rt_q;
                     st_d  = L_WACK;
                  end
               end
            end
            L_AACK, L_RACK: begin
               if ((st_q == L_AACK && rw_q) || (st_q == L_RACK && !sda_pos_q)) begin
                  oe_d  = ~rbyte[7];
                  sh_d  = {rbyte[6:0], 1'b0};
                  cnt_d = 3'h0;
                  ptr_d = ptr_q + 8'h1;
                  ra_d  = ptr_q + 8'h1;
                  rt_d  = ~rt_q;
                  st_d  = L_RDAT;
               end else begin
                  oe_d  = 1'b0;
                  cnt_d = 3'h0;
                  st_d  = (st_q == L_AACK) ? L_PTR : L_IDLE;
               end
            end
            L_PACK, L_WACK: begin
               oe_d  = 1'b0;
               cnt_d = 3'h0;
               st_d  = L_WDAT;
            end
            L_RDAT: begin
               if (cnt_q == 3'h7) begin
                  oe_d = 1'b0;
                  st_d = L_RACK;
               end else begin
                  oe_d  = ~sh_q[7];
                  sh_d  = {sh_q[6:0], 1'b0};
                  cnt_d = cnt_q + 3'h1;
               end
            end
            default: oe_d = 1'b0;
         endcase
      end
   end

   always_ff @(negedge i2c_scl or posedge reset) begin
      if (reset) begin
         {st_q, cnt_q, sh_q, ptr_q, wa_q, wd_q, ra_q} <= {L_IDLE, 43'h0};
         {rw_q, oe_q, wt_q, rt_q} <= 4'h0;
      end else begin
         {st_q, cnt_q, sh_q, ptr_q, wa_q, wd_q, ra_q} <= {st_d, cnt_d, sh_d, ptr_d, wa_d, wd_d, ra_d};
         {rw_q, oe_q, wt_q, rt_q} <= {rw_d, oe_d, wt_d, rt_d};
      end
   end

   assign i2c_sda_oe = oe_q;
   assign lk.wr_tgl  = wt_q;
   assign lk.wr_addr = wa_q;
   assign lk.wr_data = wd_q;
   assign lk.rd_tgl  = rt_q;
   assign lk.rd_addr = ra_q;
endmodule

/* core/htc_ctrl.sv */
`timescale 1ns/1ps
module htc_ctrl (
   input  wire logic        ref_clk,
   input  wire logic        reset,
   input  wire logic        hw_reset_in_n,
   input  wire logic        i2c_scl,
   input  wire logic        i2c_sda_in,
   output logic             i2c_sda_out,
   output logic             i2c_sda_oe,
   input  wire logic        scan_tick,
   input  wire logic        btn_touch_evt,
   input  wire logic        btn_release_evt,
   input  wire logic        sld_evt,
   input  wire logic        comp_done_evt,
   input  wire logic        auto_wake_req,
   input  wire logic [15:0] cap_status,
   input  wire logic [15:0] slider_pos,
   input  wire logic [7:0]  gpi_pins,
   input  wire logic [3:0]  param_addr,
   output logic [7:0]       param_data,
   output logic [1:0]       op_mode,
   output logic             comp_req,
   output logic             cfg_ready,
   output logic             host_irq_out_n
);
   htc_link_if lk ();

   htc_pkg::htc_st_e st_q, st_d;
   logic [7:0]  shd_q [16];
   logic [7:0]  shd_d [16];
   logic [7:0]  nvm_q [16];
   logic [7:0]  nvm_d [16];
   logic        nvm_ok_q, nvm_ok_d;
   logic [15:0] cnt_q, cnt_d;
   logic [3:0]  idx_q, idx_d;
   logic [1:0]  mode_q, mode_d;
   logic [1:0]  mreq_q, mreq_d;
   logic        comp_q, comp_d;
   logic        hmode_q, hmode_d;
   logic [3:0]  sadr_q, sadr_d;
   logic        arm_q, arm_d;
   logic        srst_q, srst_d;
   logic [6:0]  pend_q, pend_d;
   logic [6:0]  src_q, src_d;
   logic        irqn_q, irqn_d;
   logic [7:0]  rdat_q, rdat_d;
   logic        rack_q, rack_d;
   logic [1:0]  tgp_q, tgp_d;
   logic [7:0]  gprev_q, gprev_d;
   logic [7:0]  pdat_q, pdat_d;
   logic        rdy_q, rdy_d;

   logic        hwn_s;
   logic [1:0]  tg_s;
   logic [7:0]  gpi_s;
   logic        wr_ev, rd_ev, running, commit, in_rst;
   logic [7:0]  gpi_edge, rmux;
   logic [6:0]  new_ev;

   htc_sync2 #(.W(1)) u_hwr (
      .clk (ref_clk),
      .rst (reset),
      .d   (hw_reset_in_n),
      .q   (hwn_s)
   );

   htc_sync2 #(.W(2)) u_tgl (
      .clk (ref_clk),
      .rst (reset),
      .d   ({lk.rd_tgl, lk.wr_tgl}),
      .q   (tg_s)
   );

   htc_sync2 #(.W(8)) u_gpi (
      .clk (ref_clk),
      .rst (reset),
      .d   (gpi_pins),
      .q   (gpi_s)
   );

   htc_i2c_link u_link ( // [RULE8]
      .i2c_scl    (i2c_scl),
      .reset      (reset),
      .i2c_sda_in (i2c_sda_in),
      .i2c_sda_oe (i2c_sda_oe),
      .lk         (lk)
   );

   // open-drain line: only the enable moves
   assign i2c_sda_out = 1'b0;

   // address is quasi-static: changes only after a burn or a power reset
   assign lk.dev_addr = nvm_ok_q ? nvm_q[htc_pkg::SHD_ADDR][6:0]
                                 : htc_pkg::DEF_SLV_ADDR; // [RULE9]
   assign lk.rd_data    = rdat_q;
   assign lk.rd_ack_tgl = rack_q;

   assign wr_ev   = tg_s[0] ^ tgp_q[0];
   assign rd_ev   = tg_s[1] ^ tgp_q[1];
   assign running = (st_q == htc_pkg::ST_RUN) || (st_q == htc_pkg::ST_BURN);
   // pin low or software command holds everything but the non-volatile store, the serial link and its read response in reset
   assign in_rst  = !hwn_s || srst_q; // [RULE10] [RULE13]
   // scanning modes publish once per scan, sleep publishes at once
   assign commit  = running && (scan_tick || mode_q == htc_pkg::M_SLEEP); // [RULE15]
   assign gpi_edge = (gpi_s & ~gprev_q & shd_q[htc_pkg::SHD_RISE])
                   | (~gpi_s & gprev_q & shd_q[htc_pkg::SHD_FALL]); // [RULE18]

   // read multiplexer for the host-visible map
   always_comb begin
      case (lk.rd_addr) // [RULE5]
         htc_pkg::REG_IRQ:     rmux = {1'b0, src_q};
         htc_pkg::REG_CAPH:    rmux = cap_status[15:8];
         htc_pkg::REG_CAPL:    rmux = cap_status[7:0];
         htc_pkg::REG_SLDH:    rmux = slider_pos[15:8];
         htc_pkg::REG_SLDL:    rmux = slider_pos[7:0];
         htc_pkg::REG_GPI:     rmux = gpi_s;
         htc_pkg::REG_MODE:    rmux = {6'h0, mode_q}; // [RULE19]
         htc_pkg::REG_SHD_CTL: rmux = {6'h0, st_q == htc_pkg::ST_BURN, hmode_q};
         htc_pkg::REG_SHD_ADR: rmux = {4'h0, sadr_q};
         htc_pkg::REG_SHD_DAT: rmux = shd_q[sadr_q];
         default:              rmux = 8'h00;
      endcase
   end

   always_comb begin
      st_d     = st_q;
      shd_d    = shd_q;
      nvm_d    = nvm_q;
      nvm_ok_d = nvm_ok_q;
      cnt_d    = cnt_q;
      idx_d    = idx_q;
      mode_d   = mode_q;
      mreq_d   = mreq_q;
      comp_d   = 1'b0;
      hmode_d  = hmode_q;
      sadr_d   = sadr_q;
      arm_d    = arm_q;
      srst_d   = 1'b0;
      pend_d   = pend_q;
      src_d    = src_q;
      new_ev   = 7'h0;
      rdat_d   = rdat_q;
      rack_d   = rack_q;
      tgp_d    = tg_s;
      gprev_d  = gpi_s;
      pdat_d   = shd_q[param_addr]; // [RULE2]
      rdy_d    = running;

      if (rd_ev) begin
         rdat_d = rmux;
         rack_d = tg_s[1];
      end

      if (in_rst) begin
         st_d   = htc_pkg::ST_RST;
         for (int i = 0; i < 16; i++) begin
            shd_d[i] = 8'h00; // [RULE3]
         end
         cnt_d  = 16'h0;
         idx_d  = 4'h0;
         mode_d = htc_pkg::M_ACTIVE;
         mreq_d = htc_pkg::M_ACTIVE;
         hmode_d = 1'b0;
         sadr_d = 4'h0;
         arm_d  = 1'b0;
         pend_d = 7'h0;
         src_d  = 7'h0;
         rdy_d  = 1'b0;
      end else begin
         case (st_q)
            htc_pkg::ST_RST: begin
               st_d  = htc_pkg::ST_WAIT;
               cnt_d = 16'h0;
            end
            htc_pkg::ST_WAIT: begin
               cnt_d = cnt_q + 16'h1;
               if (cnt_q == htc_pkg::PWRUP_CYC - 16'h1) begin
                  st_d  = htc_pkg::ST_LOAD;
                  idx_d = 4'h0;
               end
            end
            htc_pkg::ST_LOAD: begin
               // non-volatile copy wins when valid, else the constant table
               shd_d[idx_q] = nvm_ok_q ? nvm_q[idx_q]
                                       : htc_pkg::factory_default(idx_q); // [RULE1] [RULE2] [RULE4]
               idx_d = idx_q + 4'h1;
               if (idx_q == htc_pkg::SHD_LAST) begin
                  st_d  = htc_pkg::ST_RUN; // [RULE3]
                  src_d = 7'h0; // [RULE22]
               end
            end
            htc_pkg::ST_BURN: begin
               cnt_d = cnt_q + 16'h1;
               if (cnt_q == htc_pkg::NVM_WR_CYC - 16'h1) begin
                  cnt_d        = 16'h0;
                  nvm_d[idx_q] = shd_q[idx_q]; // [RULE7]
                  idx_d        = idx_q + 4'h1;
                  if (idx_q == htc_pkg::SHD_LAST) begin
                     nvm_ok_d = 1'b1;
                     st_d     = htc_pkg::ST_RUN;
                     new_ev[htc_pkg::IRQ_NVMB] = 1'b1; // [RULE20]
                  end
               end
            end
            htc_pkg::ST_RUN: begin
               if (wr_ev && lk.wr_addr == htc_pkg::REG_SHD_CTL && lk.wr_data[1] && hmode_q) begin
                  st_d  = htc_pkg::ST_BURN; // [RULE7]
                  idx_d = 4'h0;
                  cnt_d = 16'h0;
               end
            end
            default: st_d = htc_pkg::ST_RST;
         endcase

         if (running && wr_ev) begin
            if (lk.wr_addr == htc_pkg::REG_SRST) begin
               // any other write to the trigger drops the armed key
               arm_d  = (lk.wr_data == htc_pkg::SRST_KEY); // [RULE14]
               srst_d = arm_q && (lk.wr_data == htc_pkg::SRST_GO); // [RULE14]
            end
            case (lk.wr_addr)
               htc_pkg::REG_MODE: begin
                  if (lk.wr_data[1:0] != 2'h3) begin
                     mreq_d = lk.wr_data[1:0];
                  end
                  comp_d = lk.wr_data[2];
               end
               htc_pkg::REG_SHD_CTL: hmode_d = lk.wr_data[0];
               htc_pkg::REG_SHD_ADR: sadr_d = lk.wr_data[3:0];
               htc_pkg::REG_SHD_DAT: begin
                  if (hmode_q && st_q == htc_pkg::ST_RUN) begin
                     shd_d[sadr_q] = lk.wr_data; // [RULE6]
                     sadr_d = sadr_q + 4'h1;
                     new_ev[htc_pkg::IRQ_SPMW] = 1'b1; // [RULE20]
                  end
               end
               default: ;
            endcase
         end

         if (running) begin
            new_ev[htc_pkg::IRQ_BTN]  = btn_touch_evt
                                      | (btn_release_evt & shd_q[htc_pkg::SHD_REL][0]); // [RULE16]
            new_ev[htc_pkg::IRQ_SLD]  = sld_evt; // [RULE17]
            new_ev[htc_pkg::IRQ_GPI]  = |gpi_edge; // [RULE18]
            new_ev[htc_pkg::IRQ_COMP] = comp_done_evt; // [RULE20]
            if (|gpi_edge && mode_q != htc_pkg::M_ACTIVE) begin
               mreq_d = htc_pkg::M_ACTIVE; // [RULE23]
            end
            if (auto_wake_req && mode_q == htc_pkg::M_DOZE) begin
               mreq_d = htc_pkg::M_ACTIVE;
            end
            if (commit && mreq_q != mode_q) begin
               mode_d = mreq_q;
               new_ev[htc_pkg::IRQ_MODE] = (mreq_q != htc_pkg::M_SLEEP); // [RULE19]
            end
         end

         // new events set in the same cycle as a clear survive
         pend_d = (commit ? 7'h0 : pend_q) | new_ev; // [RULE24]
         src_d  = ((rd_ev && lk.rd_addr == htc_pkg::REG_IRQ) ? 7'h0 : src_d)
                | (commit ? pend_q : 7'h0); // [RULE22] [RULE24]
      end

      // low through every reset and start-up, then follows the source register
      irqn_d = (running && !in_rst) ? ~|src_d : 1'b0; // [RULE11] [RULE21] [RULE22]
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         st_q     <= htc_pkg::ST_RST;
         for (int i = 0; i < 16; i++) begin
            shd_q[i] <= 8'h00;
            nvm_q[i] <= 8'h00;
         end
         nvm_ok_q <= 1'b0;
         cnt_q    <= 16'h0;
         idx_q    <= 4'h0;
         mode_q   <= htc_pkg::M_ACTIVE;
         mreq_q   <= htc_pkg::M_ACTIVE;
         comp_q   <= 1'b0;
         hmode_q  <= 1'b0;
         sadr_q   <= 4'h0;
         arm_q    <= 1'b0;
         srst_q   <= 1'b0;
         pend_q   <= 7'h0;
         src_q    <= 7'h0;
         irqn_q   <= 1'b0;
         rdat_q   <= 8'h00;
         rack_q   <= 1'b0;
         tgp_q    <= 2'h0;
         gprev_q  <= 8'h00;
         pdat_q   <= 8'h00;
         rdy_q    <= 1'b0;
      end else begin
         st_q     <= st_d;
         shd_q    <= shd_d;
         nvm_q    <= nvm_d;
         nvm_ok_q <= nvm_ok_d;
         cnt_q    <= cnt_d;
         idx_q    <= idx_d;
         mode_q   <= mode_d;
         mreq_q   <= mreq_d;
         comp_q   <= comp_d;
         hmode_q  <= hmode_d;
         sadr_q   <= sadr_d;
         arm_q    <= arm_d;
         srst_q   <= srst_d;
         pend_q   <= pend_d;
         src_q    <= src_d;
         irqn_q   <= irqn_d;
         rdat_q   <= rdat_d;
         rack_q   <= rack_d;
         tgp_q    <= tgp_d;
         gprev_q  <= gprev_d;
         pdat_q   <= pdat_d;
         rdy_q    <= rdy_d;
      end
   end

   assign host_irq_out_n = irqn_q;
   assign op_mode        = mode_q;
   assign comp_req       = comp_q;
   assign cfg_ready      = rdy_q;
   assign param_data     = pdat_q;
endmodule

/* verif/htc_i2c_host.sv */
`timescale 1ns/1ps
module htc_i2c_host (
   input  wire logic i2c_sda_oe,
   output logic      i2c_scl,
   output logic      i2c_sda_in
);
   logic sda_rel = 1'b1;
   logic nak_seen = 1'b0;
   logic s;
   // pulled-up wire
   assign i2c_sda_in = sda_rel & ~i2c_sda_oe;
   initial i2c_scl = 1'b1;
   task automatic bit_x(input logic b);
      #10 sda_rel = b;
      #52.5 i2c_scl = 1'b1;
      #62.5 s = i2c_sda_in;
      i2c_scl = 1'b0;
   endtask
   task automatic start();
      // a fresh rise with the line high, so a start after a stop is seen
      #10 {i2c_scl, sda_rel} = 2'b01;
      #52.5 i2c_scl = 1'b1;
      #31.25 sda_rel = 1'b0;
      #31.25 i2c_scl = 1'b0;
   endtask
   task automatic stop();
      #10 sda_rel = 1'b0;
      #52.5 i2c_scl = 1'b1;
      #31.25 sda_rel = 1'b1;
   endtask
   task automatic wr_byte(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) bit_x(b[i]);
      bit_x(1'b1);
      nak_seen = nak_seen | s;
   endtask
   task automatic rd_byte(input logic last, output logic [7:0] d);
      for (int i = 7; i >= 0; i--) begin
         bit_x(1'b1);
         d[i] = s;
      end
      bit_x(last);
   endtask
endmodule

/* verif/htc_ctrl_asserts.sv */
`timescale 1ns/1ps
module htc_ctrl_asserts (
   input wire logic       ref_clk,
   input wire logic       reset,
   input wire logic       hw_reset_in_n,
   input wire logic       scan_tick,
   input wire logic       btn_touch_evt,
   input wire logic       i2c_sda_out,
   input wire logic [1:0] op_mode,
   input wire logic       comp_req,
   input wire logic       cfg_ready,
   input wire logic       host_irq_out_n
);
   localparam int MAX_WAIT = 150;
   logic [8:0] wait_q;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) wait_q <= 9'h000;
      else wait_q <= cfg_ready ? 9'h000 : wait_q + 9'(wait_q != 9'h1ff);
   end
   property p_pin_hold;
      !hw_reset_in_n [*6] |-> !host_irq_out_n && !cfg_ready;
   endproperty
   a_pin_hold: assert property (p_pin_hold) else $error("pin reset leak");
   property p_rise_ready;
      $rose(host_irq_out_n) |-> ##[0:1] cfg_ready;
   endproperty
   a_rise_ready: assert property (p_rise_ready) else $error("irq released early");
   property p_pwrup_len;
      $rose(cfg_ready) |-> 16'(wait_q) >= htc_pkg::PWRUP_CYC;
   endproperty
   a_pwrup_len: assert property (p_pwrup_len) else $error("start-up too short");
   property p_scan;
      $fell(host_irq_out_n) && cfg_ready && op_mode != 2'h2 |->
         $past(scan_tick) || $past(scan_tick, 2);
   endproperty
   a_scan: assert property (p_scan) else $error("irq moved off scan tick");
   property p_evt;
      btn_touch_evt && cfg_ready && op_mode != 2'h2 |-> ##[1:MAX_WAIT] !host_irq_out_n;
   endproperty
   a_evt: assert property (p_evt) else $error("touch raised no irq");
   property p_mode;
      $changed(op_mode) && op_mode != 2'h2 && cfg_ready |-> ##[1:MAX_WAIT] !host_irq_out_n;
   endproperty
   a_mode: assert property (p_mode) else $error("no mode irq");
   property p_comp;
      comp_req |=> !comp_req;
   endproperty
   a_comp: assert property (p_comp) else $error("comp too long");
   property p_rst_irq;
      $fell(cfg_ready) |-> ##[0:2] !host_irq_out_n;
   endproperty
   a_rst_irq: assert property (p_rst_irq) else $error("irq not held in reset");
   property p_sda;
      !i2c_sda_out;
   endproperty
   a_sda: assert property (p_sda) else $error("sda driven high");
   c_ready: cover property ($rose(cfg_ready));
   c_irq: cover property ($fell(host_irq_out_n) && cfg_ready);
   c_comp: cover property (comp_req);
   c_pin: cover property (!hw_reset_in_n);
endmodule
bind htc_ctrl htc_ctrl_asserts u_asserts (.*);

/* verif/host_irq_reset_config_bench.sv */
`timescale 1ns/1ps
module host_irq_reset_config_bench;
   logic       ref_clk = 1'b0, reset = 1'b1, hw_reset_in_n = 1'b1, scan_tick = 1'b0;
   logic       i2c_scl, i2c_sda_in, i2c_sda_out, comp_req, host_irq_out_n, i2c_sda_oe, cfg_ready;
   logic [2:0] evt = 3'h0;
   logic [5:0] tick_q = 6'h00;
   logic [7:0] gpi_pins = 8'h00, param_data, rd;
   logic [3:0] param_addr = 4'h0;
   logic [1:0] op_mode;
   logic [6:0] dev_a = htc_pkg::DEF_SLV_ADDR;
   int         n_checks = 0, miscompares = 0;
   htc_ctrl u_dut (.*, .btn_touch_evt(evt[0]), .btn_release_evt(1'b0), .sld_evt(evt[1]),
      .comp_done_evt(evt[2]), .auto_wake_req(1'b0), .cap_status(16'h0000),
      .slider_pos(16'h0000));
   htc_i2c_host u_host (.*);
   always #50 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      tick_q <= tick_q + 6'h01;
      scan_tick <= &tick_q;
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic wait_irq(input logic lvl);
      for (int i = 0; i < 2000 && host_irq_out_n !== lvl; i++) @(posedge ref_clk);
   endtask
   task automatic pd(input logic [3:0] a);
      @(posedge ref_clk);
      param_addr <= a;
      cyc(3);
   endtask
   task automatic hdr(input logic [7:0] ra);
      u_host.start();
      u_host.wr_byte({dev_a, 1'b0});
      u_host.wr_byte(ra);
   endtask
   task automatic reg_wr(input logic [7:0] ra, input logic [7:0] wd);
      hdr(ra);
      u_host.wr_byte(wd);
      u_host.stop();
      cyc(8);
   endtask
   task automatic reg_rd(input logic [7:0] ra);
      hdr(ra);
      u_host.start();
      u_host.wr_byte({dev_a, 1'b1});
      u_host.rd_byte(1'b1, rd);
      u_host.stop();
      cyc(8);
   endtask
   task automatic t_pin();
      @(posedge ref_clk);
      hw_reset_in_n <= 1'b0;
      cyc(10);
      check(8'({host_irq_out_n, cfg_ready}), 8'h00);
      hw_reset_in_n <= 1'b1;
      wait_irq(1'b1);
   endtask
   task automatic t_power();
      cyc(150);
      check(8'(host_irq_out_n), 8'h00);
      wait_irq(1'b1);
      check(8'(cfg_ready), 8'h01);
      pd(4'h0);
      check(param_data, {1'b0, htc_pkg::DEF_SLV_ADDR});
      pd(4'h1);
      check(param_data, 8'h01);
   endtask
   task automatic t_shadow();
      reg_wr(htc_pkg::REG_SHD_CTL, 8'h01);
      reg_wr(htc_pkg::REG_SHD_ADR, 8'h02);
      reg_wr(htc_pkg::REG_SHD_DAT, 8'h01);
      pd(4'h2);
      check(param_data, 8'h01);
      cyc(140);
      reg_rd(htc_pkg::REG_IRQ);
      check(rd, 8'h20);
      gpi_pins <= 8'h01;
      wait_irq(1'b0);
      reg_rd(htc_pkg::REG_IRQ);
      check(rd, 8'h10);
      reg_rd(htc_pkg::REG_GPI);
      check(rd, 8'h01);
      t_pin();
      pd(4'h2);
      check(param_data, 8'h00);
      pd(4'h0);
      check(param_data, {1'b0, htc_pkg::DEF_SLV_ADDR});
   endtask
   task automatic t_events();
      @(posedge ref_clk);
      evt <= 3'h1;
      @(posedge ref_clk);
      evt <= 3'h0;
      wait_irq(1'b0);
      check(8'(host_irq_out_n), 8'h00);
      evt <= 3'h6;
      @(posedge ref_clk);
      evt <= 3'h0;
      cyc(140);
      reg_rd(htc_pkg::REG_IRQ);
      check(rd, 8'h0e);
      cyc(4);
      check(8'(host_irq_out_n), 8'h01);
      reg_wr(htc_pkg::REG_MODE, 8'h05);
      cyc(70);
      check(8'(op_mode), 8'h01);
      wait_irq(1'b0);
      reg_rd(htc_pkg::REG_IRQ);
      check(rd, 8'h01);
   endtask
   task automatic t_soft();
      reg_wr(htc_pkg::REG_SRST, htc_pkg::SRST_KEY);
      check(8'(cfg_ready), 8'h01);
      reg_wr(htc_pkg::REG_SRST, htc_pkg::SRST_GO);
      cyc(12);
      check(8'({host_irq_out_n, cfg_ready}), 8'h00);
      wait_irq(1'b1);
      check(8'(cfg_ready), 8'h01);
   endtask
   task automatic t_burn();
      reg_wr(htc_pkg::REG_SHD_CTL, 8'h01);
      reg_wr(htc_pkg::REG_SHD_ADR, 8'h00);
      reg_wr(htc_pkg::REG_SHD_DAT, 8'h33);
      cyc(140);
      reg_rd(htc_pkg::REG_IRQ);
      reg_wr(htc_pkg::REG_SHD_CTL, 8'h03);
      cyc(500);
      check(8'(host_irq_out_n), 8'h00);
      t_pin();
      pd(4'h0);
      check(param_data, 8'h33);
      dev_a = 7'h33;
      u_host.nak_seen = 1'b0;
      reg_rd(htc_pkg::REG_MODE);
      check(8'(u_host.nak_seen), 8'h00);
      dev_a = htc_pkg::DEF_SLV_ADDR;
      reg_rd(htc_pkg::REG_MODE);
      check(8'(u_host.nak_seen), 8'h01);
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      #5000000;
      miscompares++;
      stop_test();
   end
   initial begin
      cyc(2);
      reset <= 1'b0;
      t_power();
      t_shadow();
      t_events();
      t_soft();
      t_burn();
      stop_test();
   end
endmodule
